//--- hw/pph_pkg.sv
// constants, register indices and carrier types of the parallel port handshake block
// assumes an APB master with 32-bit data; register byte address is four times its index
package pph_pkg;

    localparam int          ADDR_W            = 16;
    localparam int          DATA_W            = 32;
    localparam int          PORT_W            = 8;
    localparam int          IDX_W             = 14;

    // register indices, byte address = index * 4
    localparam logic [13:0] IDX_PORT_A        = 14'h1000;
    localparam logic [13:0] IDX_CTRL          = 14'h1002;
    localparam logic [13:0] IDX_PORT_C        = 14'h1003;
    localparam logic [13:0] IDX_PORT_B        = 14'h1004;
    localparam logic [13:0] IDX_LATCH         = 14'h1005;
    localparam logic [13:0] IDX_DIR_C         = 14'h1007;

    // control register reset: edge select and strobe polarity at one, rest zero
    localparam logic [7:0]  CTRL_RESET        = 8'h03;
    localparam logic [7:0]  CTRL_WRITE_MASK   = 8'h7F;
    localparam logic [7:0]  PORT_RESET        = 8'h00;
    localparam logic [7:0]  DIR_C_RESET       = 8'h00;
    localparam logic [7:0]  LATCH_RESET       = 8'h00;

    // strobe b pulse length in bus-clock cycles
    localparam logic [1:0]  STB_PULSE_CYCLES  = 2'h2;
    localparam logic [1:0]  STB_PULSE_IDLE    = 2'h0;

    typedef struct packed {
        logic strobeAFlag;
        logic strobeAIrqEnable;
        logic portCOpenDrain;
        logic fullHandshakeSelect;
        logic handshakeDirection;
        logic pulseSelect;
        logic strobeAEdgeSelect;
        logic strobeBPolarity;
    } pph_ctrl_t;

    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
    } pph_pin_drive_t;

    typedef enum logic [1:0] {
        MODE_SIMPLE,
        MODE_IN_HS,
        MODE_OUT_HS
    } pph_mode_t;

endpackage : pph_pkg

//--- hw/pph_core.sv
// strobed and full-handshake parallel ports b and c with apb register access
// assumes pins are asynchronous to ref_clk; expAddrHigh comes from logic on ref_clk
//
// Behaviour
// RULE_01: strobe functions only in single-chip mode
// RULE_02: port b outputs data, else high address
// RULE_03: port b write pulses strobe b two cycles
// RULE_04: polarity bit sets strobe b active level
// RULE_05: strobe a edge captures port c pins
// RULE_06: port c stays general io meanwhile
// RULE_07: edge select picks falling or rising
// RULE_08: flag sets on edge, cleared by sequence
// RULE_09: interrupt enable gates flag request
// RULE_10: open-drain bit switches all eight outputs
// RULE_11: mode bit picks simple or full handshake
// RULE_12: direction bit valid only in full handshake
// RULE_13: pulse select: interlocked level or pulse
// RULE_14: input handshake: ready, latch, then negate
// RULE_15: reassert ready after latch register read
// RULE_16: input handshake allows mixed pin usage
// RULE_17: output handshake: latch write asserts strobe
// RULE_18: external side reads, then acknowledges strobe
// RULE_19: active strobe a drives latch on all lines
// RULE_20: three-state variation has no static inputs
// RULE_21: latch writes also update port c outputs
// RULE_22: reset clears port c direction bits
// RULE_23: interrupt is flag and enable
// RULE_24: output interlock negates on acknowledge edge
module pph_core
    import pph_pkg::*;
(
    input  wire logic                 ref_clk,
    input  wire logic                 sys_rst,
    input  wire logic [ADDR_W-1:0]    paddr,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [DATA_W-1:0]    pwdata,
    output logic                      pready,
    output logic      [DATA_W-1:0]    prdata,
    output logic                      pslverr,
    input  wire logic                 singleChipPin,
    input  wire logic [PORT_W-1:0]    portAPins,
    input  wire logic [PORT_W-1:0]    expAddrHigh,
    output logic      [PORT_W-1:0]    portBPins,
    input  wire logic [PORT_W-1:0]    portCIn,
    output pph_pin_drive_t            portCDrive,
    input  wire logic                 strobeAIn,
    output logic                      strobeBOut,
    output logic                      strobeAIrq
);

    pph_ctrl_t              ctrl_r;
    logic [PORT_W-1:0]      portBData_r;
    logic [PORT_W-1:0]      portCOutData_r;
    logic [PORT_W-1:0]      portCDir_r;
    logic [PORT_W-1:0]      latch_r;
    logic [DATA_W-1:0]      prdata_r;
    logic                   clearArmed_r;
    logic [1:0]             pulseCnt_r;
    logic                   readyLevel_r;
    logic                   strobeB_r;
    logic                   irq_r;
    logic [PORT_W-1:0]      portBPins_r;
    logic [PORT_W-1:0]      portCOut_r;
    logic [PORT_W-1:0]      portCOe_r;

    logic                   strASync1_r;
    logic                   strASync2_r;
    logic                   strADly_r;
    logic [PORT_W-1:0]      portCSync1_r;
    logic [PORT_W-1:0]      portCSync2_r;
    logic [PORT_W-1:0]      portASync1_r;
    logic [PORT_W-1:0]      portASync2_r;
    logic                   modeSync1_r;
    logic                   modeSync2_r;

    logic                   singleChip;
    logic                   strAEdge;
    logic                   strAActive;
    pph_mode_t              mode;
    logic                   interlocked;
    logic [IDX_W-1:0]       regIdx;
    logic                   setup;
    logic                   access;
    logic                   hit;
    logic                   wrCtrl;
    logic                   wrPortC;
    logic                   wrPortB;
    logic                   wrLatch;
    logic                   wrDirC;
    logic                   rdCtrl;
    logic                   rdLatch;
    logic                   flagClear;
    logic                   pulseLoad;
    logic                   levelSet;
    logic                   levelClr;
    logic                   stbActive;
    logic                   threeStateDrive;
    logic [PORT_W-1:0]      portCReadVal;
    logic [DATA_W-1:0]      readMux;

    // two-stage synchronisers for every pin input
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            strASync1_r  <= 1'b0;
            strASync2_r  <= 1'b0;
            strADly_r    <= 1'b0;
            portCSync1_r <= PORT_RESET;
            portCSync2_r <= PORT_RESET;
            portASync1_r <= PORT_RESET;
            portASync2_r <= PORT_RESET;
            modeSync1_r  <= 1'b0;
            modeSync2_r  <= 1'b0;
        end else begin
            strASync1_r  <= strobeAIn;
            strASync2_r  <= strASync1_r;
            strADly_r    <= strASync2_r;
            portCSync1_r <= portCIn;
            portCSync2_r <= portCSync1_r;
            portASync1_r <= portAPins;
            portASync2_r <= portASync1_r;
            modeSync1_r  <= singleChipPin;
            modeSync2_r  <= modeSync1_r;
        end
    end

    assign singleChip = modeSync2_r;
    // selected edge, suppressed outside single-chip mode
    assign strAEdge   = singleChip & (ctrl_r.strobeAEdgeSelect ? (strASync2_r & ~strADly_r)      // [RULE_07] [RULE_01]
                                                               : (~strASync2_r & strADly_r));
    assign strAActive = (strASync2_r == ctrl_r.strobeAEdgeSelect);

    always_comb begin
        mode = MODE_SIMPLE;
        case ({ctrl_r.fullHandshakeSelect, ctrl_r.handshakeDirection})                           // [RULE_11] [RULE_12]
            2'b10:   mode = MODE_IN_HS;
            2'b11:   mode = MODE_OUT_HS;
            default: mode = MODE_SIMPLE;
        endcase
    end

    assign interlocked = ctrl_r.fullHandshakeSelect & ~ctrl_r.pulseSelect;                       // [RULE_13]

    // apb decode, zero wait states
    assign regIdx  = paddr[ADDR_W-1:2];
    assign setup   = psel & ~penable;
    assign access  = psel & penable;
    assign hit     = (regIdx == IDX_PORT_A) | (regIdx == IDX_CTRL) | (regIdx == IDX_PORT_C) |
                     (regIdx == IDX_PORT_B) | (regIdx == IDX_LATCH) | (regIdx == IDX_DIR_C);
    assign wrCtrl  = access & pwrite & (regIdx == IDX_CTRL);
    assign wrPortC = access & pwrite & (regIdx == IDX_PORT_C);
    assign wrPortB = access & pwrite & (regIdx == IDX_PORT_B);
    assign wrLatch = access & pwrite & (regIdx == IDX_LATCH);
    assign wrDirC  = access & pwrite & (regIdx == IDX_DIR_C);
    assign rdCtrl  = access & ~pwrite & (regIdx == IDX_CTRL);
    assign rdLatch = access & ~pwrite & (regIdx == IDX_LATCH);
    assign pready  = 1'b1;
    assign pslverr = access & ~hit;

    // outputs read back their data, inputs read the pins
    assign portCReadVal = (portCDir_r & portCOutData_r) | (~portCDir_r & portCSync2_r);          // [RULE_06] [RULE_16]

    always_comb begin
        readMux = '0;
        case (regIdx)
            IDX_PORT_A: readMux[PORT_W-1:0] = portASync2_r;
            IDX_CTRL:   readMux[PORT_W-1:0] = ctrl_r;
            IDX_PORT_C: readMux[PORT_W-1:0] = portCReadVal;
            IDX_PORT_B: readMux[PORT_W-1:0] = portBData_r;
            IDX_LATCH:  readMux[PORT_W-1:0] = latch_r;
            IDX_DIR_C:  readMux[PORT_W-1:0] = portCDir_r;
            default:    readMux             = '0;
        endcase
    end

    // read data sampled in the setup cycle, held through access
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            prdata_r <= '0;
        end else if (setup & ~pwrite) begin
            prdata_r <= readMux;
        end
    end
    assign prdata = prdata_r;

    // data registers
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            portBData_r    <= PORT_RESET;
            portCOutData_r <= PORT_RESET;
            portCDir_r     <= DIR_C_RESET;                                                       // [RULE_22]
        end else begin
            if (wrPortB) begin
                portBData_r <= pwdata[PORT_W-1:0];
            end
            if (wrPortC | wrLatch) begin
                portCOutData_r <= pwdata[PORT_W-1:0];                                           // [RULE_21]
            end
            if (wrDirC) begin
                portCDir_r <= pwdata[PORT_W-1:0];
            end
        end
    end

    // latch: edge capture in input modes, software write otherwise
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            latch_r <= LATCH_RESET;
        end else if (strAEdge & (mode != MODE_OUT_HS)) begin
            latch_r <= portCSync2_r;                                                             // [RULE_05] [RULE_14]
        end else if (wrLatch) begin
            latch_r <= pwdata[PORT_W-1:0];                                                       // [RULE_21]
        end
    end

    // flag clear: control read with flag set, then latch access
    assign flagClear = clearArmed_r & ((mode == MODE_OUT_HS) ? wrLatch : rdLatch);               // [RULE_08]

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            clearArmed_r <= 1'b0;
        end else if (rdCtrl) begin
            clearArmed_r <= ctrl_r.strobeAFlag;
        end else if (flagClear) begin
            clearArmed_r <= 1'b0;
        end
    end

    // control register; flag is hardware-set and set wins over clear
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            ctrl_r <= CTRL_RESET;
        end else begin
            if (wrCtrl) begin
                ctrl_r[6:0] <= pwdata[6:0] & CTRL_WRITE_MASK[6:0];
            end
            if (strAEdge) begin
                ctrl_r.strobeAFlag <= 1'b1;                                                      // [RULE_08]
            end else if (flagClear) begin
                ctrl_r.strobeAFlag <= 1'b0;
            end
        end
    end

    // strobe b pulse generator
    always_comb begin
        pulseLoad = 1'b0;
        // entering input hs raises ready, entering output hs drops stale ready
        levelSet  = wrCtrl & pwdata[4] & ~pwdata[3];                                             // [RULE_14]
        levelClr  = wrCtrl & pwdata[4] & pwdata[3] & (mode != MODE_OUT_HS);                      // [RULE_17]
        case (mode)
            MODE_SIMPLE: begin
                pulseLoad = wrPortB;                                                             // [RULE_03]
            end
            MODE_IN_HS: begin
                pulseLoad = ctrl_r.pulseSelect & rdLatch;
                levelSet  = levelSet | rdLatch;                                                  // [RULE_15]
                levelClr  = levelClr | strAEdge;                                                 // [RULE_14]
            end
            MODE_OUT_HS: begin
                pulseLoad = ctrl_r.pulseSelect & wrLatch;
                levelSet  = levelSet | wrLatch;                                                  // [RULE_17]
                levelClr  = levelClr | strAEdge;                                                 // [RULE_24]
            end
            default: begin
                pulseLoad = 1'b0;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            pulseCnt_r <= STB_PULSE_IDLE;
        end else if (pulseLoad & singleChip) begin
            pulseCnt_r <= STB_PULSE_CYCLES;                                                      // [RULE_03] [RULE_13]
        end else if (pulseCnt_r != STB_PULSE_IDLE) begin
            pulseCnt_r <= pulseCnt_r - 2'h1;
        end
    end

    // interlocked level; a set in the same cycle as the edge wins
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            readyLevel_r <= 1'b0;
        end else if (levelSet) begin
            readyLevel_r <= 1'b1;
        end else if (levelClr) begin
            readyLevel_r <= 1'b0;                                                                // [RULE_14] [RULE_24]
        end
    end

    assign stbActive = singleChip & (interlocked ? readyLevel_r : (pulseCnt_r != STB_PULSE_IDLE));

    // strobe b pin, interrupt and port b pins
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            strobeB_r   <= 1'b0;
            irq_r       <= 1'b0;
            portBPins_r <= PORT_RESET;
        end else begin
            strobeB_r   <= ctrl_r.strobeBPolarity ? stbActive : ~stbActive;                      // [RULE_04]
            irq_r       <= ctrl_r.strobeAFlag & ctrl_r.strobeAIrqEnable;                         // [RULE_09] [RULE_23]
            portBPins_r <= singleChip ? portBData_r : expAddrHigh;                               // [RULE_02]
        end
    end
    assign strobeBOut = strobeB_r;
    assign strobeAIrq = irq_r;
    assign portBPins  = portBPins_r;

    // active strobe a in output handshake drives every line, no static inputs
    assign threeStateDrive = singleChip & (mode == MODE_OUT_HS) & strAActive;                    // [RULE_19] [RULE_20]

    genvar gi;
    generate
        for (gi = 0; gi < PORT_W; gi++) begin : g_port_c_pin_data
            logic drv;
            logic val;
            assign drv = singleChip & (portCDir_r[gi] | threeStateDrive);                        // [RULE_19] [RULE_01]
            assign val = threeStateDrive ? latch_r[gi] : portCOutData_r[gi];
            always_ff @(posedge ref_clk) begin
                if (sys_rst) begin
                    portCOut_r[gi] <= 1'b0;
                    portCOe_r[gi]  <= 1'b0;
                end else begin
                    portCOut_r[gi] <= val;
                    portCOe_r[gi]  <= drv & ~(ctrl_r.portCOpenDrain & val);                     // [RULE_10]
                end
            end
        end
    endgenerate
    assign portCDrive.out = portCOut_r;
    assign portCDrive.oe  = portCOe_r;

    logic stbOutActive;
    assign stbOutActive = (strobeB_r == ctrl_r.strobeBPolarity);

    strobe_b_out_pulse_len_a: assert property (@(posedge ref_clk) disable iff (sys_rst)                  // [RULE_03]
        (wrPortB && mode == MODE_SIMPLE && singleChip && !wrCtrl) |-> ##2 stbOutActive [*2])
        else $error("strobe b pulse after port b write is not two cycles");

    strobe_b_out_idle_level_a: assert property (@(posedge ref_clk) disable iff (sys_rst)                 // [RULE_04]
        !singleChip |=> (strobeB_r == !$past(ctrl_r.strobeBPolarity)))
        else $error("strobe b idle level does not follow polarity");

    latch_capture_a: assert property (@(posedge ref_clk) disable iff (sys_rst)                   // [RULE_05]
        (strAEdge && mode != MODE_OUT_HS) |=> (latch_r == $past(portCSync2_r)))
        else $error("latch did not capture port c on strobe a edge");

    flag_set_a: assert property (@(posedge ref_clk) disable iff (sys_rst)                        // [RULE_08]
        strAEdge |=> ctrl_r.strobeAFlag [*1] ##1 (strobeAIrq == ctrl_r.strobeAIrqEnable || $changed(ctrl_r)))
        else $error("strobe a flag or interrupt missing after edge");

    irq_gate_a: assert property (@(posedge ref_clk) disable iff (sys_rst)                        // [RULE_09]
        (!ctrl_r.strobeAIrqEnable || !ctrl_r.strobeAFlag) |=> !strobeAIrq)
        else $error("interrupt raised while gated");

    open_drain_a: assert property (@(posedge ref_clk) disable iff (sys_rst)                      // [RULE_10]
        $past(ctrl_r.portCOpenDrain) |-> ((portCDrive.oe & portCDrive.out) == '0))
        else $error("open-drain port c line driven high");

    in_hs_negate_a: assert property (@(posedge ref_clk) disable iff (sys_rst)                    // [RULE_14]
        (mode == MODE_IN_HS && interlocked && strAEdge && !levelSet && !wrCtrl) |=> !readyLevel_r ##1 !stbOutActive)
        else $error("ready not negated after input strobe");

    in_hs_reassert_a: assert property (@(posedge ref_clk) disable iff (sys_rst)                  // [RULE_15]
        (mode == MODE_IN_HS && interlocked && rdLatch && singleChip && !wrCtrl) |-> ##2 stbOutActive)
        else $error("ready not reasserted after latch read");

    out_hs_assert_a: assert property (@(posedge ref_clk) disable iff (sys_rst)                   // [RULE_17]
        (mode == MODE_OUT_HS && wrLatch && singleChip && !wrCtrl) |-> ##2 stbOutActive)
        else $error("strobe b not asserted after latch write");

    three_state_drive_a: assert property (@(posedge ref_clk) disable iff (sys_rst)               // [RULE_19]
        (threeStateDrive && !ctrl_r.portCOpenDrain) |=> (portCDrive.out == $past(latch_r)) && (portCDrive.oe == '1))
        else $error("latch not driven on all lines while strobe a active");

    reset_dir_a: assert property (@(posedge ref_clk)                                             // [RULE_22]
        $fell(sys_rst) |-> (portCDir_r == '0 && portCDrive.oe == '0))
        else $error("port c direction not cleared by reset");

    expanded_quiet_a: assert property (@(posedge ref_clk) disable iff (sys_rst)                  // [RULE_01]
        (!$past(sys_rst) && $past(!singleChip)) |-> (portCDrive.oe == '0 && portBPins == $past(expAddrHigh)))
        else $error("port activity outside single-chip mode");

endmodule : pph_core

//--- tb/pph_ext_model.sv
// far-side system model: drives port c pins and strobe a, reads the byte
// assumes tb pulses ackGo for one cycle; strobe a idles at the inverse of activeHigh
module pph_ext_model
    import pph_pkg::*;
(
    input  wire logic           ref_clk,
    input  wire logic           sys_rst,
    input  wire pph_pin_drive_t portCDrive,
    input  wire logic           ackGo,
    input  wire logic [3:0]     ackDelay,
    input  wire logic           activeHigh,
    input  wire logic [7:0]     extData,
    output logic                strobeAIn,
    output logic [7:0]          portCIn,
    output logic [7:0]          rxByte
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [4:0] cnt;
    // driven lines win over the far side's own levels
    assign portCIn = (portCDrive.oe & portCDrive.out) | (~portCDrive.oe & extData);
    // active strobe a for four cycles at the end of the wait
    assign strobeAIn = ((cnt != 5'h0) && (cnt <= 5'h4)) ? activeHigh : ~activeHigh;
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            cnt <= 5'h0;
            rxByte <= 8'h00;
        end else if (ackGo) begin
            cnt <= {1'b0, ackDelay} + 5'h6;
        end else if (cnt != 5'h0) begin
            cnt <= cnt - 5'h1;
            // read the data before acknowledging it
            if (cnt == 5'h5) begin
                rxByte <= portCIn;
            end
        end
    end
endmodule : pph_ext_model

//--- tb/test_parallel_port_handshake.sv
// top testbench: apb register access, port b strobe, port c handshakes
// assumes pready answers within the watchdog span
module test_parallel_port_handshake;
    timeunit 1ns;
    timeprecision 1ps;
    import pph_pkg::*;
    logic ref_clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
    logic [ADDR_W-1:0] paddr = '0;
    logic [DATA_W-1:0] pwdata = '0, prdata, d;
    logic singleChipPin = 1, strobeAIn, strobeBOut, strobeAIrq, ackGo = 0, slv;
    logic [7:0] portAPins = 8'h00, expAddrHigh = 8'h00, portBPins, portCIn, extData = 8'h00, rxByte;
    logic [3:0] ackDelay = 4'h1;
    pph_pin_drive_t portCDrive;
    int errTotal = 0, checks = 0, n;
    pph_core u_pph_core (.ref_clk(ref_clk), .sys_rst(sys_rst), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .singleChipPin(singleChipPin), .portAPins(portAPins),
        .expAddrHigh(expAddrHigh), .portBPins(portBPins), .portCIn(portCIn), .portCDrive(portCDrive),
        .strobeAIn(strobeAIn), .strobeBOut(strobeBOut), .strobeAIrq(strobeAIrq));
    pph_ext_model u_pph_ext_model (.ref_clk(ref_clk), .sys_rst(sys_rst), .portCDrive(portCDrive),
        .ackGo(ackGo), .ackDelay(ackDelay), .activeHigh(1'b1), .extData(extData),
        .strobeAIn(strobeAIn), .portCIn(portCIn), .rxByte(rxByte));
    initial begin
        forever #5 ref_clk = ~ref_clk;
    end
    task automatic apb(input logic wr, input logic [13:0] idx, input logic [7:0] wd);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h00_0000, wd};
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1) @(posedge ref_clk);
        d = prdata;
        slv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            errTotal++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic waitc(input int c);
        repeat (c) @(posedge ref_clk);
    endtask : waitc
    task automatic ack(input logic [3:0] dly);
        ackDelay <= dly;
        ackGo <= 1'b1;
        @(posedge ref_clk);
        ackGo <= 1'b0;
        waitc(34);
    endtask : ack
    task automatic pulses(input logic act);
        n = 0;
        repeat (10) begin
            @(posedge ref_clk);
            if (strobeBOut === act) n++;
        end
    endtask : pulses
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", checks, errTotal);
        if (errTotal == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : summarize
    initial begin
        waitc(6000);
        errTotal++;
        summarize();
    end
    initial begin
        waitc(12);
        sys_rst <= 1'b0;
        apb(0, IDX_CTRL, 8'h00); chk(d, {24'h0, CTRL_RESET});
        apb(0, IDX_DIR_C, 8'h00); chk(d, {24'h0, DIR_C_RESET});
        chk(portCDrive.oe, 8'h00);
        apb(0, 14'h1001, 8'h00); chk(slv, 1);
        $display("reset test done");
        for (int pol = 0; pol < 2; pol++) begin
            apb(1, IDX_CTRL, 8'h02 | pol[7:0]);
            apb(1, IDX_PORT_B, 8'h5A + pol[7:0]);
            pulses(pol[0]); chk(n, 2);
            chk(portBPins, 8'h5A + pol[7:0]);
        end
        $display("port b strobe test done");
        extData <= 8'hC3;
        apb(1, IDX_CTRL, 8'h43);
        ack(4'h1); chk(strobeAIrq, 1);
        apb(0, IDX_CTRL, 8'h00); chk(d[7], 1);
        apb(0, IDX_LATCH, 8'h00); chk(d, 32'h0000_00C3);
        apb(0, IDX_CTRL, 8'h00); chk(d[7], 0);
        waitc(3); chk(strobeAIrq, 0);
        apb(1, IDX_CTRL, 8'h03);
        ack(4'h1); chk(strobeAIrq, 0);
        $display("strobed input test done");
        apb(1, IDX_CTRL, 8'h13);
        waitc(4); chk(strobeBOut, 1);
        extData <= 8'h3C;
        ack(4'h9); chk(strobeBOut, 0);
        apb(0, IDX_LATCH, 8'h00); chk(d, 32'h0000_003C);
        waitc(4); chk(strobeBOut, 1);
        apb(1, IDX_DIR_C, 8'h0F);
        apb(1, IDX_PORT_C, 8'h5A);
        apb(0, IDX_PORT_C, 8'h00); chk(d, 32'h0000_003A);
        $display("input handshake test done");
        apb(1, IDX_DIR_C, 8'hFF);
        apb(1, IDX_CTRL, 8'h1B);
        waitc(3); chk(strobeBOut, 0);
        apb(1, IDX_LATCH, 8'hA5);
        waitc(4); chk(portCDrive.out, 8'hA5);
        chk(strobeBOut, 1);
        ack(4'h1); chk(rxByte, 8'hA5);
        chk(strobeBOut, 0);
        apb(1, IDX_CTRL, 8'h1F);
        apb(1, IDX_LATCH, 8'h96);
        pulses(1'b1); chk(n, 2);
        apb(1, IDX_CTRL, 8'h3B);
        apb(1, IDX_LATCH, 8'h0F);
        waitc(4); chk(portCDrive.oe, 8'hF0);
        $display("output handshake test done");
        singleChipPin <= 1'b0;
        expAddrHigh <= 8'h81;
        waitc(8); chk(portBPins, 8'h81);
        chk(portCDrive.oe, 8'h00);
        $display("expanded mode test done");
        summarize();
    end
endmodule : test_parallel_port_handshake
